// >>> hdl/adcfc_params.svh
`ifndef ADCFC_PARAMS_SVH
`define ADCFC_PARAMS_SVH
`define ADCFC_OFF_STATUS    8'h00
`define ADCFC_OFF_FIFO      8'h04
`define ADCFC_OFF_CMD       8'h08
`define ADCFC_OFF_MUXGAIN   8'h0C
`define ADCFC_OFF_START     8'h10
`define ADCFC_OFF_CLEAR     8'h14
`define ADCFC_OFF_CAL       8'h18
`define ADCFC_OFF_SEQGO     8'h1C
`define ADCFC_OFF_COUNT     8'h20
`define ADCFC_OFF_INTERVAL  8'h24
`define ADCFC_OFF_SAMPLE    8'h28
`define ADCFC_ST_AVAIL      0
`define ADCFC_ST_OVFL       1
`define ADCFC_ST_OVRUN      2
`define ADCFC_ST_CAL        3
`define ADCFC_ST_SEQ        4
`define ADCFC_CMD_FMT       0
`define ADCFC_CMD_EXTPACE   1
`define ADCFC_CMD_EXTBEGIN  2
`define ADCFC_CMD_PRETRIG   3
`define ADCFC_CMD_RESET     4'h0
`define ADCFC_MUX_RESET     8'h00
`define ADCFC_CLK_HZ        25000000
`define ADCFC_CAL_MS        750
`define ADCFC_CAL_CYC       ((`ADCFC_CAL_MS * 25000) )
`define ADCFC_CONV_NS       20000
`define ADCFC_CONV_CYC      (`ADCFC_CONV_NS / 40)
`define ADCFC_AVAIL_US      100
`define ADCFC_AVAIL_CYC     (`ADCFC_AVAIL_US * 25)
`define ADCFC_FIFO_DEPTH    16
`endif

// >>> hdl/adcfc_pkg.sv
`default_nettype none
package adcfc_pkg;
  typedef enum logic [1:0] {
    ADC_IDLE,
    ADC_CONV,
    ADC_CAL
  } adcfc_conv_t;
  typedef struct packed {
    logic [1:0] gain;
    logic [3:0] channel;
  } adcfc_sel_t;
endpackage
`default_nettype wire

// >>> hdl/adcfc_core.sv
// Local design decisions: the register addresses and the AXI4-Lite register port.
`include "adcfc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module adcfc_core #(
  parameter int unsigned CAL_CYCLES  = `ADCFC_CAL_CYC,
  parameter int unsigned CONV_CYCLES = `ADCFC_CONV_CYC,
  parameter int unsigned DEPTH       = `ADCFC_FIFO_DEPTH
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        external_convert_n,
  input  wire logic        acq_begin_trigger_n,
  input  wire logic        acq_end_trigger,
  input  wire logic [15:0] adc_sample,
  output logic [1:0]       amp_gain,
  output logic [3:0]       mux_channel,
  output logic             converting
);
  localparam int unsigned CW = $clog2(CAL_CYCLES + 1);
  localparam int unsigned AW = $clog2(DEPTH);

  // AXI write path
  logic        aw_have_r, w_have_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        wr_go;
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  logic wr_cmd, wr_mux, wr_start, wr_clear, wr_cal, wr_go_seq;
  logic wr_count, wr_interval;
  wire [7:0] wa = {aw_addr_r[7:2], 2'b00};
  assign wr_cmd      = wr_go && wa == `ADCFC_OFF_CMD;
  assign wr_mux      = wr_go && wa == `ADCFC_OFF_MUXGAIN;
  assign wr_start    = wr_go && wa == `ADCFC_OFF_START;
  assign wr_clear    = wr_go && wa == `ADCFC_OFF_CLEAR;
  assign wr_cal      = wr_go && wa == `ADCFC_OFF_CAL;
  assign wr_go_seq   = wr_go && wa == `ADCFC_OFF_SEQGO;
  assign wr_count    = wr_go && wa == `ADCFC_OFF_COUNT;
  assign wr_interval = wr_go && wa == `ADCFC_OFF_INTERVAL;

  // Control registers
  logic [3:0]         cmd_r;
  adcfc_pkg::adcfc_sel_t sel_r;
  logic [15:0]        count_load_r, interval_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= `ADCFC_CMD_RESET;
      sel_r <= '0;
      count_load_r <= 16'h0002;
      interval_r <= 16'h0002;
    end else begin
      if (wr_cmd) cmd_r <= w_data_r[3:0];
      if (wr_mux) begin
        sel_r.gain <= w_data_r[7:6];
        sel_r.channel <= w_data_r[3:0];
      end
      if (wr_count) count_load_r <= w_data_r[15:0];
      if (wr_interval) interval_r <= w_data_r[15:0];
    end
  end
  assign amp_gain = sel_r.gain;
  assign mux_channel = sel_r.channel;

  // External pins: falling edges
  logic ext_n_d_r, beg_n_d_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_n_d_r <= 1'b1;
      beg_n_d_r <= 1'b1;
    end else begin
      ext_n_d_r <= external_convert_n;
      beg_n_d_r <= acq_begin_trigger_n;
    end
  end
  wire ext_pulse = ext_n_d_r && !external_convert_n;
  wire beg_pulse = beg_n_d_r && !acq_begin_trigger_n;

  // Multi-conversion sequence
  logic        seq_r, armed_r;
  logic [15:0] ival_cnt_r, samp_cnt_r;
  logic        pace_pulse, seq_conv;
  assign pace_pulse = cmd_r[`ADCFC_CMD_EXTPACE] ? ext_pulse
                      : (ival_cnt_r == 16'h0001);
  assign seq_conv = seq_r && pace_pulse;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r <= 1'b0;
      armed_r <= 1'b0;
      ival_cnt_r <= 16'h0000;
      samp_cnt_r <= 16'h0000;
    end else if (wr_clear) begin
      seq_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (!seq_r) begin
      if (wr_go_seq
          || (cmd_r[`ADCFC_CMD_EXTBEGIN] && beg_pulse)) begin
        seq_r <= 1'b1;
        armed_r <= !cmd_r[`ADCFC_CMD_PRETRIG];
        samp_cnt_r <= count_load_r;
        ival_cnt_r <= interval_r;
      end
    end else begin
      if (!cmd_r[`ADCFC_CMD_EXTPACE])
        ival_cnt_r <= (ival_cnt_r == 16'h0001) ? interval_r
                      : ival_cnt_r - 16'h0001;
      if (!armed_r && acq_end_trigger) armed_r <= 1'b1;
      if (seq_conv && armed_r) begin
        samp_cnt_r <= samp_cnt_r - 16'h0001;
        if (samp_cnt_r == 16'h0001) seq_r <= 1'b0;
      end
    end
  end

  // Converter engine
  adcfc_pkg::adcfc_conv_t st_r;
  logic [CW-1:0] tmr_r;
  logic          conv_req, conv_done, cal_done, ovrun_r;
  assign conv_req = wr_start
                    || (!seq_r && ext_pulse)
                    || seq_conv;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= adcfc_pkg::ADC_IDLE;
      tmr_r <= '0;
    end else begin
      unique case (st_r)
        adcfc_pkg::ADC_IDLE: begin
          if (wr_cal) begin
            st_r <= adcfc_pkg::ADC_CAL;
            tmr_r <= CW'(CAL_CYCLES - 1);
          end else if (conv_req) begin
            st_r <= adcfc_pkg::ADC_CONV;
            tmr_r <= CW'(CONV_CYCLES - 1);
          end
        end
        adcfc_pkg::ADC_CONV, adcfc_pkg::ADC_CAL: begin
          if (tmr_r == '0) st_r <= adcfc_pkg::ADC_IDLE;
          else tmr_r <= tmr_r - CW'(1);
        end
      endcase
    end
  end
  assign conv_done = st_r == adcfc_pkg::ADC_CONV && tmr_r == '0;
  assign cal_done  = st_r == adcfc_pkg::ADC_CAL && tmr_r == '0;
  assign converting = st_r != adcfc_pkg::ADC_IDLE;
  always_ff @(posedge aclk) begin
    if (!aresetn) ovrun_r <= 1'b0;
    else if (conv_req && st_r == adcfc_pkg::ADC_CONV) ovrun_r <= 1'b1;
    else if (wr_clear) ovrun_r <= 1'b0;
  end

  // Result FIFO
  logic [15:0]   mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0]   cnt_r;
  logic          ovfl_r, cal_flag_r, push, pop, full;
  wire  [7:0]    ra = {s_axi_araddr[7:2], 2'b00};
  assign full = cnt_r == (AW+1)'(DEPTH);
  assign push = conv_done && !full;
  assign pop  = s_axi_arvalid && s_axi_arready
                && ra == `ADCFC_OFF_FIFO && cnt_r != '0;
  always_ff @(posedge aclk) begin
    if (push) mem_r[wp_r] <= adc_sample;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_clear) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + AW'(1);
      if (pop) rp_r <= rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ovfl_r <= 1'b0;
    else if (conv_done && full) ovfl_r <= 1'b1;
    else if (wr_clear) ovfl_r <= 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) cal_flag_r <= 1'b0;
    else if (cal_done) cal_flag_r <= 1'b1;
    else if (wr_clear) cal_flag_r <= 1'b0;
  end
  wire avail = cnt_r != '0 || cal_flag_r;

  // Format: converter gives signed code; set bit flips MSB
  wire [15:0] head = mem_r[rp_r];
  wire [15:0] fmt_data = cmd_r[`ADCFC_CMD_FMT]
                         ? {~head[15], head[14:0]}
                         : head;

  // AXI read path
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      unique case (ra)
        `ADCFC_OFF_STATUS: s_axi_rdata <= {27'h0, seq_r,
          st_r == adcfc_pkg::ADC_CAL, ovrun_r, ovfl_r, avail};
        `ADCFC_OFF_FIFO: s_axi_rdata <= {16'h0000, fmt_data};
        `ADCFC_OFF_CMD: s_axi_rdata <= {28'h0, cmd_r};
        `ADCFC_OFF_MUXGAIN: s_axi_rdata <= {24'h0, sel_r.gain, 2'b00,
          sel_r.channel};
        `ADCFC_OFF_COUNT: s_axi_rdata <= {16'h0000, count_load_r};
        `ADCFC_OFF_INTERVAL: s_axi_rdata <= {16'h0000, interval_r};
        `ADCFC_OFF_SAMPLE: s_axi_rdata <= {16'h0000, samp_cnt_r};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Cycles from an accepted start until a result shows
  localparam logic [11:0] AVAIL_LIMIT = 12'(`ADCFC_AVAIL_CYC);
  logic [11:0] wait_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || avail || wr_clear) begin
      wait_cnt_r <= 12'h000;
    end else if ((st_r == adcfc_pkg::ADC_IDLE && conv_req && !wr_cal)
                 || wait_cnt_r != 12'h000) begin
      wait_cnt_r <= wait_cnt_r + 12'h001;
    end
  end

  // Assertions
  AST_START_CONV: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_start && st_r == adcfc_pkg::ADC_IDLE && !wr_cal
    |=> st_r == adcfc_pkg::ADC_CONV)
    else $error("start write did not begin conversion");
  AST_NO_RESTART: assert property (
    @(posedge aclk) disable iff (!aresetn)
    conv_req && st_r == adcfc_pkg::ADC_CONV && tmr_r != '0
    |=> tmr_r == $past(tmr_r) - 1 && ovrun_r)
    else $error("request during conversion restarted it");
  AST_EXT_CONV: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ext_pulse && !seq_r && st_r == adcfc_pkg::ADC_IDLE && !wr_cal
    |=> converting)
    else $error("external pulse did not begin conversion");
  AST_PUSH: assert property (
    @(posedge aclk) disable iff (!aresetn)
    conv_done && !full && !wr_clear && !pop
    |=> cnt_r == $past(cnt_r) + 1)
    else $error("result not pushed");
  AST_POP: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pop && !push && !wr_clear |=> cnt_r == $past(cnt_r) - 1)
    else $error("read did not remove result");
  AST_AVAIL: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && ra == `ADCFC_OFF_STATUS
    |=> s_axi_rdata[`ADCFC_ST_AVAIL] == $past(cnt_r != '0 || cal_flag_r))
    else $error("available flag wrong");
  AST_AVAIL_TIME: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wait_cnt_r < AVAIL_LIMIT)
    else $error("result not available in time");
  AST_OVFL: assert property (
    @(posedge aclk) disable iff (!aresetn)
    conv_done && full && !wr_clear && !pop
    |=> ovfl_r && cnt_r == $past(cnt_r))
    else $error("overflow not flagged");
  AST_OVFL_HOLD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ovfl_r && !wr_clear |=> ovfl_r)
    else $error("overflow flag dropped without clear");
  AST_CLEAR: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_clear && !conv_done && !conv_req
    |=> cnt_r == '0 && !ovfl_r && !ovrun_r)
    else $error("clear did not empty");
  AST_FMT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pop |=> s_axi_rdata[15:0]
      == ($past(head) ^ {$past(cmd_r[`ADCFC_CMD_FMT]), 15'h0000}))
    else $error("format mapping wrong");
  AST_SEQ_END: assert property (
    @(posedge aclk) disable iff (!aresetn)
    seq_r && armed_r && seq_conv && samp_cnt_r == 16'h0001 && !wr_clear
    |=> !seq_r)
    else $error("sequence did not end at zero");
  AST_PRE_HOLD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    seq_r && !armed_r && !wr_clear
    |=> samp_cnt_r == $past(samp_cnt_r))
    else $error("pretrigger counter moved");
  AST_CAL_DONE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cal_done && !wr_clear |=> avail)
    else $error("calibration end not flagged");

  // Cover points
  COV_CONV: cover property (@(posedge aclk) conv_done && !full);
  COV_OVFL: cover property (@(posedge aclk) conv_done && full);
  COV_SEQ: cover property (@(posedge aclk) seq_r && !$past(seq_r));
  COV_CAL: cover property (@(posedge aclk) cal_done);
  COV_EXT: cover property (@(posedge aclk)
    seq_conv && cmd_r[`ADCFC_CMD_EXTPACE]);
endmodule
`default_nettype wire

// >>> tb/adcfc_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcfc_front_model (
  input  wire logic        converting,
  input  wire logic [15:0] level,
  output logic [15:0]      adc_sample
);
  // Code is held only while a conversion runs, inverse otherwise
  assign adc_sample = converting ? level : ~level;
endmodule
`default_nettype wire

// >>> tb/adc_conversion_fifo_control_test.sv
`include "adcfc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_fifo_control_test;
  typedef struct packed {
    logic        fmt;
    logic [15:0] smp;
    logic [15:0] exp;
  } adcfc_row_t;
  localparam adcfc_row_t ROWS [5] = '{
    '{1'b0, 16'h0000, 16'h0000}, '{1'b1, 16'h0000, 16'h8000},
    '{1'b0, 16'hC000, 16'hC000}, '{1'b1, 16'h7FFF, 16'hFFFF},
    '{1'b1, 16'h8000, 16'h0000}};
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, external_convert_n = 1'b1;
  logic        acq_begin_trigger_n = 1'b1, acq_end_trigger = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, converting;
  logic [1:0]  s_axi_bresp, s_axi_rresp, amp_gain;
  logic [3:0]  mux_channel;
  logic [15:0] adc_sample, level = 16'h0000;
  int          n_fail = 0, total_checks = 0, cyc = 0, t0, cnt;
  adcfc_core #(.CAL_CYCLES(50), .CONV_CYCLES(20), .DEPTH(16)) adcfc_core_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .external_convert_n, .acq_begin_trigger_n,
    .acq_end_trigger, .adc_sample, .amp_gain, .mux_channel, .converting);
  adcfc_front_model adcfc_front_model_inst (
    .converting(converting), .level(level), .adc_sample(adc_sample));
  always #20 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_port(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int   n;
    b = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b && n < 50) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w  = s_axi_wvalid && s_axi_wready;
      b  = s_axi_bvalid;
      n++;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    if (!b) n_fail++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ar, r;
    int   n;
    r = 1'b0;
    n = 0;
    d = 32'h0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r && n < 50) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      r  = s_axi_rvalid;
      if (r) d = s_axi_rdata;
      n++;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
    if (!r) n_fail++;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk_word("register", e, d);
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    st = ~{32{v}};
    while (st[b] !== v && n < 400) begin
      rd(`ADCFC_OFF_STATUS, st);
      n++;
    end
    chk_word("status_poll", {31'h0, v}, {31'h0, st[b]});
  endtask
  task automatic conv_once(input logic [15:0] v);
    int n;
    n = 0;
    level <= v;
    wr(`ADCFC_OFF_START, 32'h0);
    do begin
      @(negedge aclk);
      n++;
    end while (converting !== 1'b0 && n < 100);
  endtask
  task automatic pulse(input logic beg);
    @(posedge aclk);
    if (beg) acq_begin_trigger_n <= 1'b0;
    else external_convert_n <= 1'b0;
    @(posedge aclk);
    acq_begin_trigger_n <= 1'b1;
    external_convert_n <= 1'b1;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk_port("ports", 8'h00, {1'b0, amp_gain, mux_channel, converting});
    rd_chk(`ADCFC_OFF_STATUS, 32'h0);
    rd_chk(`ADCFC_OFF_CMD, 32'h0);
    rd_chk(`ADCFC_OFF_MUXGAIN, 32'h0);
    rd_chk(8'hFC, 32'h0);
    wr(`ADCFC_OFF_MUXGAIN, 32'h0000_00C5);
    wr(`ADCFC_OFF_COUNT, 32'h0);
    rd_chk(`ADCFC_OFF_COUNT, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`ADCFC_OFF_CLEAR, 32'h0);
      wr(`ADCFC_OFF_CMD, {31'h0, ROWS[i].fmt});
      t0 = cyc;
      conv_once(ROWS[i].smp);
      poll(0, 1'b1);
      chk_word("avail_time", 32'h1, {31'h0, (cyc - t0) <= `ADCFC_AVAIL_CYC});
      rd(`ADCFC_OFF_FIFO, st);
      chk_word("fifo", {16'h0, ROWS[i].exp}, {16'h0, st[15:0]});
      rd_chk(`ADCFC_OFF_STATUS, 32'h0);
    end
    @(negedge aclk);
    chk_port("ports", 8'h6A, {1'b0, amp_gain, mux_channel, converting});
    rd_chk(`ADCFC_OFF_MUXGAIN, 32'h0000_00C5);
    level <= 16'h1234;
    pulse(1'b0);
    poll(0, 1'b1);
    rd_chk(`ADCFC_OFF_FIFO, 32'h0000_9234);
    wr(`ADCFC_OFF_CLEAR, 32'h0);
    for (int i = 0; i < 17; i++) conv_once(16'h0100 + i[15:0]);
    rd_chk(`ADCFC_OFF_STATUS, 32'h3);
    wr(`ADCFC_OFF_START, 32'h0);
    conv_once(16'h0FFF);
    rd_chk(`ADCFC_OFF_STATUS, 32'h7);
    for (int i = 0; i < 16; i++) rd_chk(`ADCFC_OFF_FIFO, 32'h8100 + i);
    rd_chk(`ADCFC_OFF_STATUS, 32'h6);
    wr(`ADCFC_OFF_CLEAR, 32'h0);
    rd_chk(`ADCFC_OFF_STATUS, 32'h0);
    wr(`ADCFC_OFF_CAL, 32'h0);
    @(negedge aclk);
    chk_port("converting", 8'h01, {7'h0, converting});
    t0 = cyc;
    poll(0, 1'b1);
    chk_word("cal_time", 32'h1, {31'h0, (cyc - t0) inside {[40:70]}});
    wr(`ADCFC_OFF_CLEAR, 32'h0);
    rd_chk(`ADCFC_OFF_STATUS, 32'h0);
    wr(`ADCFC_OFF_CMD, 32'h1);
    wr(`ADCFC_OFF_COUNT, 32'h3);
    wr(`ADCFC_OFF_INTERVAL, 32'h28);
    wr(`ADCFC_OFF_SEQGO, 32'h0);
    poll(4, 1'b0);
    repeat (40) @(posedge aclk);
    cnt = 0;
    rd(`ADCFC_OFF_STATUS, st);
    while (st[0] === 1'b1 && cnt < 20) begin
      rd(`ADCFC_OFF_FIFO, st);
      rd(`ADCFC_OFF_STATUS, st);
      cnt++;
    end
    chk_word("seq_count", 32'h3, cnt);
    wr(`ADCFC_OFF_CMD, 32'h9);
    wr(`ADCFC_OFF_COUNT, 32'h2);
    wr(`ADCFC_OFF_SEQGO, 32'h0);
    repeat (300) @(posedge aclk);
    rd(`ADCFC_OFF_STATUS, st);
    chk_word("pretrig_run", 32'h11, st & 32'h11);
    rd_chk(`ADCFC_OFF_SAMPLE, 32'h2);
    acq_end_trigger <= 1'b1;
    poll(4, 1'b0);
    acq_end_trigger <= 1'b0;
    wr(`ADCFC_OFF_CLEAR, 32'h0);
    wr(`ADCFC_OFF_CMD, 32'h5);
    wr(`ADCFC_OFF_COUNT, 32'h2);
    pulse(1'b1);
    rd(`ADCFC_OFF_STATUS, st);
    chk_word("ext_begin", 32'h10, st & 32'h10);
    poll(4, 1'b0);
    repeat (40) @(posedge aclk);
    wr(`ADCFC_OFF_CLEAR, 32'h0);
    wr(`ADCFC_OFF_CMD, 32'h3);
    wr(`ADCFC_OFF_SEQGO, 32'h0);
    repeat (100) @(posedge aclk);
    rd(`ADCFC_OFF_STATUS, st);
    chk_word("ext_pace_idle", 32'h10, st & 32'h1F);
    pulse(1'b0);
    repeat (30) @(posedge aclk);
    pulse(1'b0);
    poll(4, 1'b0);
    repeat (30) @(posedge aclk);
    rd_chk(`ADCFC_OFF_STATUS, 32'h1);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk_port("ports", 8'h00, {1'b0, amp_gain, mux_channel, converting});
    rd_chk(`ADCFC_OFF_STATUS, 32'h0);
    rd_chk(`ADCFC_OFF_CMD, 32'h0);
    rd_chk(`ADCFC_OFF_MUXGAIN, 32'h0);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
